// ---- core/ovuv_trip.sv ----
// Overvoltage and undervoltage start, trip and indicator logic.
// Functional notes
// R1 - All three phases evaluated; switch 1 selects single phase.
// R2 - Over threshold held through start delay asserts over_start.
// R3 - Switch 2 chooses one of two overvoltage start delays.
// R4 - Over trip after operate time, or level dependent delay in inverse mode.
// R5 - Switch 3 selects definite or inverse overvoltage timing.
// R6 - Definite mode: switches 4 and 5 select operate time range.
// R7 - Inverse mode: switch 4 selects curve family A or B.
// R8 - Inverse mode ignores switch 5.
// R9 - Under threshold held through start delay asserts under_start.
// R10 - Switch 7 chooses one of two undervoltage start delays.
// R11 - Under trip after definite operate time only.
// R12 - Switch 8 selects undervoltage operate time range.
// R13 - Switch 6 enables internal undervoltage blocking.
// R14 - Blocking suppresses undervoltage start and trip below 0.2 rated.
// R15 - under_trip_inhibit suppresses under_trip only.
// R16 - Block inputs routed to stages by blocking switches.
// R17 - Indicator mode switches set each indicator self or manual reset.
// R18 - Indicator yellow while started, red once tripped.
// R19 - Manual indicators latch until reset push or remote command.
// R20 - Front end supplies synchronous per-phase threshold flags.
// R21 - Stage outputs and timers clear when condition lapses.
// R22 - Inverse delay taken from externally supplied per-level value.
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
module ovuv_trip
	import ovuv_pkg::*;
#(
	parameter int TICK = TICK_CYCLES,
	parameter logic [TW-1:0] OV_START_A = 24'd50,
	parameter logic [TW-1:0] OV_START_B = 24'd100,
	parameter logic [TW-1:0] UV_START_A = 24'd50,
	parameter logic [TW-1:0] UV_START_B = 24'd100
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// Measurement front end
	input wire phase_flags_t flags_in,
	input wire logic [TW-1:0] inv_delay_a_in,
	input wire logic [TW-1:0] inv_delay_b_in,
	// Blocking and reset inputs
	input wire logic block_input_one_in,
	input wire logic block_input_two_in,
	input wire logic block_input_three_in,
	input wire logic under_trip_inhibit_in,
	input wire logic led_reset_push_in,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Stage outputs and indicators
	output logic over_start_out,
	output logic over_trip_out,
	output logic under_start_out,
	output logic under_trip_out,
	output led_t over_led_out,
	output led_t under_led_out
);

	// ==========================================================
	// Registers
	logic [31:0] switch_r;
	logic [TW-1:0] ov_time_r;
	logic [TW-1:0] uv_time_r;
	logic led_clear_r;
	logic uv_blocked_r;
	logic [7:0] front_switch_group;
	logic [3:0] indicator_mode_switches;
	logic [5:0] blocking_config_switches;
	assign front_switch_group = switch_r[7:0];
	assign indicator_mode_switches = switch_r[11:8];
	assign blocking_config_switches = switch_r[17:12];

	// ==========================================================
	// AXI4-Lite slave
	logic aw_hold_r;
	logic w_hold_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic wr_go;
	assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] val, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = val[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_hold_r && !s_axi_awready;
			s_axi_wready <= !w_hold_r && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				unique case (aw_addr_r)
					REG_SWITCH, REG_OV_TIME, REG_UV_TIME, REG_CMD,
					REG_STATUS: s_axi_bresp <= RESP_OKAY;
					default: s_axi_bresp <= RESP_SLVERR;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
			end
		end
	end

	// Switch and time registers; the status word is read-only.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			switch_r <= SWITCH_RST;
			ov_time_r <= TIME_RST[TW-1:0];
			uv_time_r <= TIME_RST[TW-1:0];
			led_clear_r <= 1'b0;
		end else begin
			led_clear_r <= 1'b0;
			if (wr_go) begin
				unique case (aw_addr_r)
					REG_SWITCH: switch_r <= merge(switch_r, w_data_r, w_strb_r);
					REG_OV_TIME: ov_time_r <= TW'(merge(32'(ov_time_r),
						w_data_r, w_strb_r));
					REG_UV_TIME: uv_time_r <= TW'(merge(32'(uv_time_r),
						w_data_r, w_strb_r));
					REG_CMD: led_clear_r <= w_strb_r[0] &&
						w_data_r[CMD_LED_RESET]; // [R19]
					default: ;
				endcase
			end
		end
	end
	logic [31:0] status_word;
	assign status_word = {26'h0, over_led_out.red || under_led_out.red,
		over_start_out, over_trip_out, under_start_out, under_trip_out,
		uv_blocked_r};
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= RESP_OKAY;
				unique case (s_axi_araddr)
					REG_SWITCH: s_axi_rdata <= switch_r;
					REG_OV_TIME: s_axi_rdata <= 32'(ov_time_r);
					REG_UV_TIME: s_axi_rdata <= 32'(uv_time_r);
					REG_STATUS: s_axi_rdata <= status_word;
					REG_CMD: s_axi_rdata <= 32'h0000_0000;
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
	// ==========================================================
	// Time base: timers count ticks of TICK_US.
	logic [31:0] tick_cnt_r;
	logic tick_r;
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			tick_cnt_r <= 32'h0000_0000;
			tick_r <= 1'b0;
		end else begin
			tick_r <= (tick_cnt_r == 32'(TICK - 1));
			tick_cnt_r <= (tick_cnt_r == 32'(TICK - 1)) ? 32'h0000_0000 :
				tick_cnt_r + 32'h0000_0001;
		end
	end
	// ==========================================================
	// Phase evaluation and blocking
	logic [2:0] phase_mask;
	logic over_any;
	logic under_any;
	logic low_any;
	logic [2:0] blk_in;
	assign phase_mask = front_switch_group[SW_SINGLE] ? 3'b001 : 3'b111; // [R1]
	assign over_any = |(flags_in.over & phase_mask); // [R20]
	assign under_any = |(flags_in.under & phase_mask);
	assign low_any = |(flags_in.low & phase_mask);
	assign blk_in = {block_input_three_in, block_input_two_in,
		block_input_one_in};
	// Each block input has one two-bit group selecting stages it blocks.
	genvar g;
	logic [2:0] blk_ov;
	logic [2:0] blk_uv;
	generate
		for (g = 0; g < 3; g++) begin : g_blk
			assign blk_ov[g] = blk_in[g] &&
				blocking_config_switches[g*2 + BLK_OV]; // [R16]
			assign blk_uv[g] = blk_in[g] &&
				blocking_config_switches[g*2 + BLK_UV]; // [R16]
		end
	endgenerate
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			uv_blocked_r <= 1'b0;
		end else begin
			uv_blocked_r <= front_switch_group[SW_UV_BLOCK] && low_any; // [R13] [R14]
		end
	end
	logic ov_cond;
	logic uv_cond;
	assign ov_cond = over_any && !(|blk_ov); // [R16]
	assign uv_cond = under_any && !(|blk_uv) && !uv_blocked_r; // [R16] [R14]

	// ==========================================================
	// Delay selection
	logic [TW-1:0] ov_start_dly;
	logic [TW-1:0] uv_start_dly;
	logic [TW-1:0] ov_op_dly;
	logic [TW-1:0] uv_op_dly;
	logic [1:0] ov_range;
	assign ov_start_dly = front_switch_group[SW_OV_START] ? OV_START_B :
		OV_START_A; // [R3]
	assign uv_start_dly = front_switch_group[SW_UV_START] ? UV_START_B :
		UV_START_A; // [R10]
	assign ov_range = {front_switch_group[SW_RANGE_B],
		front_switch_group[SW_RANGE_A]}; // [R6]
	// Ranges scale the set time by 1, 10 or 100 ticks.
	always_comb begin
		if (front_switch_group[SW_OV_INV]) begin // [R5]
			ov_op_dly = front_switch_group[SW_RANGE_A] ? inv_delay_b_in :
				inv_delay_a_in; // [R7] [R8] [R22]
		end else begin
			unique case (ov_range)
				2'b00: ov_op_dly = ov_time_r;
				2'b01: ov_op_dly = TW'(ov_time_r * RANGE_X10);
				default: ov_op_dly = TW'(ov_time_r * RANGE_X100);
			endcase
		end
	end
	assign uv_op_dly = front_switch_group[SW_UV_RANGE] ?
		TW'(uv_time_r * RANGE_X10) : uv_time_r; // [R12]

	// ==========================================================
	// Stage timers
	logic [TW-1:0] ov_cnt_r;
	logic [TW-1:0] uv_cnt_r;
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ov_cnt_r <= '0;
			over_start_out <= 1'b0;
			over_trip_out <= 1'b0;
		end else if (!ov_cond) begin
			ov_cnt_r <= '0; // [R21]
			over_start_out <= 1'b0;
			over_trip_out <= 1'b0;
		end else if (tick_r) begin
			if (!over_start_out) begin
				if (ov_cnt_r >= ov_start_dly) begin
					over_start_out <= 1'b1; // [R2]
					ov_cnt_r <= '0;
				end else begin
					ov_cnt_r <= ov_cnt_r + 1'b1;
				end
			end else if (ov_cnt_r >= ov_op_dly) begin
				over_trip_out <= 1'b1; // [R4]
			end else begin
				ov_cnt_r <= ov_cnt_r + 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			uv_cnt_r <= '0;
			under_start_out <= 1'b0;
			under_trip_out <= 1'b0;
		end else if (!uv_cond) begin
			uv_cnt_r <= '0; // [R21] [R14]
			under_start_out <= 1'b0;
			under_trip_out <= 1'b0;
		end else begin
			if (under_trip_inhibit_in) begin
				under_trip_out <= 1'b0; // [R15]
			end
			if (tick_r) begin
				if (!under_start_out) begin
					if (uv_cnt_r >= uv_start_dly) begin
						under_start_out <= 1'b1; // [R9]
						uv_cnt_r <= '0;
					end else begin
						uv_cnt_r <= uv_cnt_r + 1'b1;
					end
				end else if (uv_cnt_r >= uv_op_dly) begin
					under_trip_out <= !under_trip_inhibit_in; // [R11]
				end else begin
					uv_cnt_r <= uv_cnt_r + 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// Indicators: manual ones latch; a new event beats a clear.
	logic led_clr;
	assign led_clr = led_clear_r || led_reset_push_in; // [R19]
	function automatic logic ind(input logic cur, input logic ev,
		input logic manual, input logic clr);
		return ev || (manual && cur && !clr);
	endfunction : ind
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			over_led_out <= '0;
			under_led_out <= '0;
		end else begin
			over_led_out.yellow <= ind(over_led_out.yellow, over_start_out,
				indicator_mode_switches[IND_OV_START], led_clr); // [R17] [R18]
			over_led_out.red <= ind(over_led_out.red, over_trip_out,
				indicator_mode_switches[IND_OV_TRIP], led_clr); // [R18]
			under_led_out.yellow <= ind(under_led_out.yellow, under_start_out,
				indicator_mode_switches[IND_UV_START], led_clr); // [R17]
			under_led_out.red <= ind(under_led_out.red, under_trip_out,
				indicator_mode_switches[IND_UV_TRIP], led_clr); // [R19]
		end
	end

endmodule : ovuv_trip

// ---- core/ovuv_pkg.sv ----
// Package with constants and carrier types of the voltage trip logic.
package ovuv_pkg;

	// ==========================================================
	// Clock and timing
	localparam int CLK_HZ = 50000000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
	localparam int TW = 24;
	localparam int RANGE_X10 = 10;
	localparam int RANGE_X100 = 100;

	// ==========================================================
	// Front switch positions, index = position minus one
	localparam int SW_SINGLE = 0;
	localparam int SW_OV_START = 1;
	localparam int SW_OV_INV = 2;
	localparam int SW_RANGE_A = 3;
	localparam int SW_RANGE_B = 4;
	localparam int SW_UV_BLOCK = 5;
	localparam int SW_UV_START = 6;
	localparam int SW_UV_RANGE = 7;

	// ==========================================================
	// Indicator mode switches: 1 means manual reset
	localparam int IND_OV_START = 0;
	localparam int IND_OV_TRIP = 1;
	localparam int IND_UV_START = 2;
	localparam int IND_UV_TRIP = 3;

	// ==========================================================
	// Blocking routing: one 2-bit group per block input
	localparam int BLK_OV = 0;
	localparam int BLK_UV = 1;

	// ==========================================================
	// AXI4-Lite register map
	localparam logic [7:0] REG_SWITCH = 8'h00;
	localparam logic [7:0] REG_OV_TIME = 8'h04;
	localparam logic [7:0] REG_UV_TIME = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_CMD = 8'h10;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam logic [31:0] SWITCH_RST = 32'h0000_0000;
	localparam logic [31:0] TIME_RST = 32'h0000_0064;
	localparam int CMD_LED_RESET = 0;

	typedef struct packed {
		logic [2:0] over;
		logic [2:0] under;
		logic [2:0] low;
	} phase_flags_t;

	typedef struct packed {
		logic yellow;
		logic red;
	} led_t;

endpackage : ovuv_pkg

// ---- bench/ovuv_front_model.sv ----
// Model of the voltage measuring front end feeding the trip logic.
`timescale 1ns/100ps
module ovuv_front_model
	import ovuv_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// Commanded levels {over, under, low}
	input wire logic [8:0] level_in,
	// Flags toward the trip logic
	output phase_flags_t flags_out
);
	// ==========================================================
	// Comparators
	// A phase below 0.2 of rated is also below the under threshold.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			flags_out <= '0;
		end else begin
			flags_out.over <= level_in[8:6];
			flags_out.under <= level_in[5:3] | level_in[2:0];
			flags_out.low <= level_in[2:0];
		end
	end
endmodule : ovuv_front_model

// ---- bench/ovuv_trip_asserts.sv ----
// Concurrent checks on the ports of the voltage trip logic.
`timescale 1ns/100ps
module ovuv_trip_asserts
	import ovuv_pkg::*;
#(
	parameter int TICK = TICK_CYCLES,
	parameter logic [TW-1:0] OV_START_A = 24'd50
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// Watched inputs
	input wire phase_flags_t flags_in,
	input wire logic under_trip_inhibit_in,
	// Watched outputs
	input wire logic over_start_out,
	input wire logic over_trip_out,
	input wire logic under_start_out,
	input wire logic under_trip_out,
	input wire led_t over_led_out,
	input wire led_t under_led_out
);
	localparam int OV_MIN = (int'(OV_START_A) - 1) * TICK;
	int ov_run_r;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	// ==========================================================
	// Helpers
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ov_run_r <= 0;
		end else if (|flags_in.over) begin
			ov_run_r <= ov_run_r + 1;
		end else begin
			ov_run_r <= 0;
		end
	end
	sequence ov_gone;
		(flags_in.over == 3'h0) [*2];
	endsequence
	sequence uv_gone;
		(flags_in.under == 3'h0) [*2];
	endsequence
	// ==========================================================
	// Assertions
	AST_OV_CLEAR: assert property (ov_gone |-> !over_start_out &&
		!over_trip_out) else $error("over stage active after lapse");
	AST_UV_CLEAR: assert property (uv_gone |-> !under_start_out &&
		!under_trip_out) else $error("under stage active after lapse");
	AST_OV_ORDER: assert property (over_trip_out |-> over_start_out)
		else $error("over trip without start");
	AST_UV_ORDER: assert property (under_trip_out |-> under_start_out)
		else $error("under trip without start");
	AST_INHIBIT: assert property (under_trip_inhibit_in [*3] |->
		!under_trip_out) else $error("under trip while inhibited");
	AST_RED: assert property ($rose(over_trip_out) |=> over_led_out.red)
		else $error("red indicator missing after trip");
	AST_YELLOW: assert property ($rose(under_start_out) |=>
		under_led_out.yellow || under_led_out.red)
		else $error("indicator dark after start");
	AST_OV_YELLOW: assert property ($rose(over_start_out) |=>
		over_led_out.yellow) else $error("over start indicator dark");
	AST_OV_DELAY: assert property ($rose(over_start_out) |->
		ov_run_r >= OV_MIN) else $error("over start too early");
endmodule : ovuv_trip_asserts

bind ovuv_trip ovuv_trip_asserts #(.TICK(TICK), .OV_START_A(OV_START_A)) chk (
	.core_clk_in, .rst_in, .flags_in, .under_trip_inhibit_in,
	.over_start_out, .over_trip_out, .under_start_out, .under_trip_out,
	.over_led_out, .under_led_out);

// ---- bench/tb_ovuv_trip.sv ----
// Self-checking bench of the voltage trip logic.
`timescale 1ns/100ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
	err_total++; $display("unexpected %s exp %h got %h", n, e, s); end end
module tb_ovuv_trip;
	import ovuv_pkg::*;
	// ==========================================================
	// Signals
	logic core_clk_in = 0, rst_in = 1, led_reset_push_in = 0;
	phase_flags_t flags_in;
	logic [8:0] lvl = 0;
	logic [TW-1:0] inv_delay_a_in = 24'd2, inv_delay_b_in = 24'd100;
	logic block_input_one_in = 0, block_input_two_in = 0;
	logic block_input_three_in = 0, under_trip_inhibit_in = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, lfsr = 32'he63b2607;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_bvalid, s_axi_rvalid;
	logic s_axi_awready, s_axi_wready, s_axi_arready;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic over_start_out, over_trip_out, under_start_out, under_trip_out;
	led_t over_led_out, under_led_out;
	logic [33:0] notes[$];
	logic [33:0] nt;
	logic [8:0] ov;
	int err_total = 0, num_checks = 0;
	always #10 core_clk_in = ~core_clk_in;
	ovuv_trip #(.TICK(5), .OV_START_A(24'd2), .OV_START_B(24'd8),
		.UV_START_A(24'd2), .UV_START_B(24'd8)) dut (.core_clk_in, .rst_in,
		.flags_in, .inv_delay_a_in, .inv_delay_b_in, .block_input_one_in,
		.block_input_two_in, .block_input_three_in, .under_trip_inhibit_in,
		.led_reset_push_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .over_start_out, .over_trip_out,
		.under_start_out, .under_trip_out, .over_led_out, .under_led_out);
	ovuv_front_model front (.core_clk_in, .rst_in, .level_in(lvl),
		.flags_out(flags_in));
	// ==========================================================
	// Result monitor
	always @(posedge core_clk_in) begin
		if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
			nt = notes.size() ? notes.pop_front() : 'x;
			if (s_axi_bvalid) `CHK("bresp", nt, {s_axi_bresp, 32'h0})
			else `CHK("rdata", nt, {s_axi_rresp, s_axi_rdata})
		end
	end
	// ==========================================================
	// Tasks
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], 1'b0} ^ (v[31] ? 32'h0400_0007 : 32'h0000_0000);
	endfunction : lfsr_next
	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		int n;
		@(posedge core_clk_in);
		notes.push_back({r, 32'h0});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (n = 0; n < 50; n++) begin
			@(posedge core_clk_in);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 0;
		if (n == 50) begin
			err_total++;
			stop_test();
		end
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		int n;
		@(posedge core_clk_in);
		notes.push_back(e);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		for (n = 0; n < 50; n++) begin
			@(posedge core_clk_in);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 0;
		if (n == 50) begin
			err_total++;
			stop_test();
		end
	endtask : rd
	// Applies switches and levels, reads status, then lets the stage lapse.
	task automatic sc(input logic [31:0] sw, input logic [8:0] fl,
		input logic [3:0] ctl, input int t, input logic [31:0] e1, e2);
		wr(REG_SWITCH, sw, RESP_OKAY);
		lvl <= fl;
		{under_trip_inhibit_in, block_input_three_in, block_input_two_in,
			block_input_one_in} <= ctl;
		repeat (t) @(posedge core_clk_in);
		rd(REG_STATUS, {RESP_OKAY, e1});
		lvl <= 0;
		{under_trip_inhibit_in, block_input_three_in, block_input_two_in,
			block_input_one_in} <= 4'h0;
		repeat (6) @(posedge core_clk_in);
		rd(REG_STATUS, {RESP_OKAY, e2});
	endtask : sc
	// ==========================================================
	// Main sequence
	initial begin
		repeat (12) @(posedge core_clk_in);
		rst_in <= 0;
		repeat (2) @(posedge core_clk_in);
		rd(REG_OV_TIME, {RESP_OKAY, TIME_RST});
		rd(REG_SWITCH, {RESP_OKAY, SWITCH_RST});
		wr(8'h14, 32'h1, RESP_SLVERR);
		rd(8'h14, {RESP_SLVERR, 32'h0});
		wr(REG_OV_TIME, 32'h8, RESP_OKAY);
		wr(REG_UV_TIME, 32'h8, RESP_OKAY);
		lfsr = lfsr_next(lfsr);
		inv_delay_b_in <= 24'd100 + lfsr[5:0];
		ov = {3'b001 << (lfsr % 3), 6'h0};
		sc(32'h0, ov, 4'h0, 22, 32'h10, 32'h0);
		sc(32'h0, ov, 4'h0, 75, 32'h38, 32'h0);
		sc(32'h1a, ov, 4'h0, 30, 32'h0, 32'h0);
		sc(32'h1a, ov, 4'h0, 60, 32'h10, 32'h0);
		sc(32'h08, ov, 4'h0, 75, 32'h10, 32'h0);
		sc(32'h04, ov, 4'h0, 50, 32'h38, 32'h0);
		sc(32'h14, ov, 4'h0, 50, 32'h38, 32'h0);
		sc(32'h0c, ov, 4'h0, 50, 32'h10, 32'h0);
		sc(32'h01, 9'h100, 4'h0, 50, 32'h0, 32'h0);
		sc(32'h01, 9'h040, 4'h0, 22, 32'h10, 32'h0);
		sc(32'h0, 9'h008, 4'h0, 22, 32'h04, 32'h0);
		sc(32'h0, 9'h010, 4'h0, 75, 32'h26, 32'h0);
		sc(32'h80, 9'h008, 4'h0, 75, 32'h04, 32'h0);
		sc(32'h40, 9'h008, 4'h0, 30, 32'h0, 32'h0);
		sc(32'h20, 9'h001, 4'h0, 75, 32'h01, 32'h0);
		sc(32'h0, 9'h001, 4'h0, 75, 32'h26, 32'h0);
		sc(32'h0, 9'h008, 4'h8, 75, 32'h04, 32'h0);
		for (int k = 0; k < 3; k++) begin
			sc(32'h1 << (12 + 2 * k), ov, 4'h1 << k, 75, 32'h0, 32'h0);
			sc(32'h2 << (12 + 2 * k), 9'h008, 4'h1 << k, 75, 0, 0);
		end
		sc(32'h200, ov, 4'h0, 75, 32'h38, 32'h20);
		wr(REG_CMD, 32'h1, RESP_OKAY);
		rd(REG_STATUS, {RESP_OKAY, 32'h0});
		sc(32'h200, ov, 4'h0, 75, 32'h38, 32'h20);
		led_reset_push_in <= 1;
		@(posedge core_clk_in);
		led_reset_push_in <= 0;
		rd(REG_STATUS, {RESP_OKAY, 32'h0});
		@(posedge core_clk_in);
		stop_test();
	end
endmodule : tb_ovuv_trip
